//--- ptb_time_base.sv
`timescale 1ns/1ns
`default_nettype none
module ptb_time_base import ptb_pkg::*; #(
    parameter int HAS_EXTENSION = 0,
    parameter int TRIP_COUNT = 3,
    parameter int COMP_COUNT = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] compareBValue,
    input wire logic pwmInA,
    input wire logic pwmInB,
    input wire logic [TRIP_COUNT-1:0] tripInputs,
    input wire logic [COMP_COUNT-1:0] compOutputs,
    input wire logic syncChainIn,
    output logic syncChainOut,
    output logic pwmOutputA,
    output logic pwmOutputAEn,
    output logic pwmOutputB,
    output logic pwmOutputBEn,
    output logic counterAtZeroEvent,
    output logic counterAtPeriodEvent,
    output logic generalInterruptRequest,
    output logic tripInterruptRequest,
    output logic conversionStartA,
    output logic conversionStartB
);
    initial begin
        if (TRIP_COUNT < 1 || TRIP_COUNT > 4 || COMP_COUNT < 1 || COMP_COUNT > 4) begin
            $error("ptb_time_base: trip and comparator counts must be 1 to 4");
        end
    end

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    logic [15:0] control_reg, phase_reg, counter_reg, period_reg, phaseExt_reg, periodExt_reg;
    logic [15:0] tripSel_reg, tripCtl_reg, evtSel_reg, dcCtl_reg, dcCapture_reg;
    logic [3:0] divCount_reg;
    logic tick_reg, countDown_reg, syncPending_reg;
    logic [3:0] oneShot_reg;
    logic cbcTrip_reg, tripFlag_reg, dcEvent_reg;
    logic [7:0] blankCount_reg;
    logic [2:0] evtFlags_reg;
    logic [3:0] evtFlagsView;
    logic busWrite, busRead;
    logic [5:0] wordIdx;
    logic syncAccepted, atZero, atPeriod, tripActive, dcRaw, dcFiltered;
    logic intPulse, socAPulse, socBPulse, intFire, socAFire, socBFire;
    logic [3:0] tripWide, compWide;
    ptb_mode_t mode;

    assign wordIdx = wb_adr_i[7:2];
    // Write lands at the edge where the master samples ack high
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign mode = ptb_mode_t'(control_reg[CTL_MODE_LO +: 2]);
    assign atZero = (counter_reg == ZERO16);
    assign atPeriod = (counter_reg == period_reg);
    assign syncAccepted = (syncChainIn && control_reg[CTL_SYNC_IN_EN]) ||
                          (busWrite && wordIdx == IDX_CONTROL && wb_sel_i[0] &&
                           wb_dat_i[CTL_SW_SYNC]);
    assign tripWide = 4'(tripInputs);
    assign compWide = 4'(compOutputs);

    // Wishbone slave, registered ack one cycle after strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (busRead) begin
            case (wordIdx)
                IDX_CONTROL: wb_dat_o <= {16'h0000, control_reg & 16'hFFBF};
                IDX_STATUS: wb_dat_o <= {30'h00000000, atPeriod, countDown_reg};
                IDX_PHASE: wb_dat_o <= {16'h0000, phase_reg};
                IDX_COUNTER: wb_dat_o <= {16'h0000, counter_reg};
                IDX_PERIOD, IDX_PERIOD_MIRROR: wb_dat_o <= {16'h0000, period_reg};
                IDX_PHASE_EXT: wb_dat_o <= HAS_EXTENSION != 0 ? {16'h0000, phaseExt_reg} : 32'h0;
                IDX_PERIOD_EXT, IDX_PERIOD_EXT_MIRROR:
                    wb_dat_o <= HAS_EXTENSION != 0 ? {16'h0000, periodExt_reg} : 32'h0;
                IDX_TRIP_SEL: wb_dat_o <= {16'h0000, tripSel_reg};
                IDX_TRIP_CTL: wb_dat_o <= {16'h0000, tripCtl_reg};
                IDX_TRIP_FLAGS: wb_dat_o <= {26'h0, oneShot_reg, cbcTrip_reg, tripFlag_reg};
                IDX_EVT_SEL: wb_dat_o <= {16'h0000, evtSel_reg};
                IDX_EVT_FLAGS: wb_dat_o <= {28'h0, evtFlagsView};
                IDX_DC_CTL: wb_dat_o <= {16'h0000, dcCtl_reg};
                IDX_DC_CAPTURE: wb_dat_o <= {15'h0000, dcEvent_reg, dcCapture_reg};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
    assign evtFlagsView = {1'b0, evtFlags_reg};

    // Configuration registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_reg <= 16'h0003;
            phase_reg <= ZERO16;
            phaseExt_reg <= ZERO16;
            periodExt_reg <= ZERO16;
            tripSel_reg <= ZERO16;
            tripCtl_reg <= 16'h000F;
            evtSel_reg <= ZERO16;
            dcCtl_reg <= ZERO16;
        end else if (busWrite) begin
            case (wordIdx)
                IDX_CONTROL: control_reg <= merge16(control_reg, wb_dat_i, wb_sel_i);
                IDX_PHASE: phase_reg <= merge16(phase_reg, wb_dat_i, wb_sel_i);
                IDX_PHASE_EXT: phaseExt_reg <= merge16(phaseExt_reg, wb_dat_i, wb_sel_i);
                IDX_PERIOD_EXT, IDX_PERIOD_EXT_MIRROR:
                    periodExt_reg <= merge16(periodExt_reg, wb_dat_i, wb_sel_i);
                IDX_TRIP_SEL: tripSel_reg <= merge16(tripSel_reg, wb_dat_i, wb_sel_i);
                IDX_TRIP_CTL: tripCtl_reg <= merge16(tripCtl_reg, wb_dat_i, wb_sel_i);
                IDX_EVT_SEL: evtSel_reg <= merge16(evtSel_reg, wb_dat_i, wb_sel_i);
                IDX_DC_CTL: dcCtl_reg <= merge16(dcCtl_reg, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            period_reg <= PERIOD_RESET;
        end else if (busWrite && (wordIdx == IDX_PERIOD || wordIdx == IDX_PERIOD_MIRROR)) begin
            period_reg <= merge16(period_reg, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            divCount_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else if (divCount_reg >= control_reg[CTL_DIV_HI:CTL_DIV_LO]) begin
            divCount_reg <= 4'h0;
            tick_reg <= 1'b1;
        end else begin
            divCount_reg <= divCount_reg + 4'h1;
            tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncPending_reg <= 1'b0;
        end else if (syncAccepted) begin
            syncPending_reg <= 1'b1;
        end else if (tick_reg) begin
            syncPending_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            counter_reg <= ZERO16;
            countDown_reg <= 1'b0;
        end else if (busWrite && wordIdx == IDX_COUNTER) begin
            counter_reg <= merge16(counter_reg, wb_dat_i, wb_sel_i);
        end else if (tick_reg) begin
            if ((syncPending_reg || syncAccepted) && control_reg[CTL_PHASE_EN]) begin
                counter_reg <= phase_reg;
                countDown_reg <= control_reg[CTL_PHASE_DIR];
            end else begin
                case (mode)
                    CNT_UP: begin
                        countDown_reg <= 1'b0;
                        counter_reg <= atPeriod ? ZERO16 : counter_reg + 16'h0001;
                    end
                    CNT_DOWN: begin
                        countDown_reg <= 1'b1;
                        counter_reg <= atZero ? period_reg : counter_reg - 16'h0001;
                    end
                    CNT_UPDOWN: begin
                        if (!countDown_reg && atPeriod) begin
                            countDown_reg <= 1'b1;
                            counter_reg <= counter_reg - 16'h0001;
                        end else if (countDown_reg && atZero) begin
                            countDown_reg <= 1'b0;
                            counter_reg <= counter_reg + 16'h0001;
                        end else if (countDown_reg) begin
                            counter_reg <= counter_reg - 16'h0001;
                        end else begin
                            counter_reg <= counter_reg + 16'h0001;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Event outputs, one pulse per tick
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            counterAtZeroEvent <= 1'b0;
            counterAtPeriodEvent <= 1'b0;
        end else begin
            counterAtZeroEvent <= tick_reg && atZero;
            counterAtPeriodEvent <= tick_reg && atPeriod;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncChainOut <= 1'b0;
        end else begin
            case (ptb_synco_t'(control_reg[CTL_SYNCO_LO +: 2]))
                SO_SYNC_IN: syncChainOut <= syncAccepted;
                SO_ZERO: syncChainOut <= tick_reg && atZero;
                SO_COMPARE_B_VALUE: syncChainOut <= tick_reg && counter_reg == compareBValue;
                default: syncChainOut <= 1'b0;
            endcase
        end
    end

    // compare event from comparators and trips
    assign dcRaw = |(compWide & dcCtl_reg[DC_CMP_EN_LO +: 4]) |
                   |(tripWide & dcCtl_reg[DC_TRIP_EN_LO +: 4]);
    assign dcFiltered = dcRaw && !(dcCtl_reg[DC_FILT_BLANK] && blankCount_reg != 8'h00);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blankCount_reg <= 8'h00;
            dcCapture_reg <= ZERO16;
            dcEvent_reg <= 1'b0;
        end else begin
            if (tick_reg && atZero) begin
                blankCount_reg <= dcCtl_reg[DC_BLANK_LEN_LO +: 6] == 6'h00 ? 8'h00 :
                                  {2'h0, dcCtl_reg[DC_BLANK_LEN_LO +: 6]};
            end else if (tick_reg && blankCount_reg != 8'h00) begin
                blankCount_reg <= blankCount_reg - 8'h01;
            end
            dcEvent_reg <= dcFiltered;
            if (dcFiltered && !dcEvent_reg && dcCtl_reg[DC_FILT_CAP]) begin
                dcCapture_reg <= counter_reg;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oneShot_reg <= 4'h0;
            cbcTrip_reg <= 1'b0;
            tripFlag_reg <= 1'b0;
        end else begin
            if (busWrite && wordIdx == IDX_TRIP_FLAGS && wb_sel_i[0]) begin
                oneShot_reg <= (oneShot_reg & ~wb_dat_i[5:2]) | (tripWide & tripSel_reg[3:0]);
                tripFlag_reg <= (tripFlag_reg & ~wb_dat_i[0]) | tripActive;
            end else begin
                oneShot_reg <= oneShot_reg | (tripWide & tripSel_reg[3:0]);
                tripFlag_reg <= tripFlag_reg | tripActive;
            end
            if ((tripWide & tripSel_reg[7:4]) != 4'h0 || (dcEvent_reg && tripSel_reg[8])) begin
                cbcTrip_reg <= 1'b1;
            end else if (tick_reg && atZero) begin
                cbcTrip_reg <= 1'b0;
            end
        end
    end
    assign tripActive = (oneShot_reg != 4'h0) || cbcTrip_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwmOutputA <= 1'b0;
            pwmOutputAEn <= 1'b1;
            pwmOutputB <= 1'b0;
            pwmOutputBEn <= 1'b1;
        end else begin
            pwmOutputA <= pwmInA;
            pwmOutputAEn <= 1'b1;
            pwmOutputB <= pwmInB;
            pwmOutputBEn <= 1'b1;
            if (tripActive && !tripCtl_reg[TRC_BYPASS]) begin
                case (ptb_trip_act_t'(tripCtl_reg[TRC_A_LO +: 2]))
                    TRIP_HIGH: pwmOutputA <= 1'b1;
                    TRIP_LOW: pwmOutputA <= 1'b0;
                    TRIP_HIZ: pwmOutputAEn <= 1'b0;
                    default: ;
                endcase
                case (ptb_trip_act_t'(tripCtl_reg[TRC_B_LO +: 2]))
                    TRIP_HIGH: pwmOutputB <= 1'b1;
                    TRIP_LOW: pwmOutputB <= 1'b0;
                    TRIP_HIZ: pwmOutputBEn <= 1'b0;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tripInterruptRequest <= 1'b0;
        end else begin
            tripInterruptRequest <= tripFlag_reg && tripCtl_reg[TRC_INT_EN];
        end
    end

    function automatic logic evtPick(input logic [3:0] sel, input logic z, input logic p);
        evtPick = (sel[0] && z) || (sel[1] && p) || (sel[2] && (z || p));
    endfunction
    assign intPulse = evtSel_reg[ES_INT_LO + 3] && evtPick(evtSel_reg[ES_INT_LO +: 4],
                      counterAtZeroEvent, counterAtPeriodEvent);
    assign socAPulse = evtSel_reg[ES_SOCA_LO + 3] && evtPick(evtSel_reg[ES_SOCA_LO +: 4],
                       counterAtZeroEvent, counterAtPeriodEvent);
    assign socBPulse = evtSel_reg[ES_SOCB_LO + 3] && evtPick(evtSel_reg[ES_SOCB_LO +: 4],
                       counterAtZeroEvent, counterAtPeriodEvent);

    ptb_event_prescale uIntPre (.core_clk(core_clk), .rst(rst), .eventIn(intPulse),
        .rate(evtSel_reg[ES_PRESC_LO +: 2]), .fire(intFire));
    ptb_event_prescale uSocAPre (.core_clk(core_clk), .rst(rst), .eventIn(socAPulse),
        .rate(evtSel_reg[ES_PRESC_LO +: 2]), .fire(socAFire));
    ptb_event_prescale uSocBPre (.core_clk(core_clk), .rst(rst), .eventIn(socBPulse),
        .rate(evtSel_reg[ES_PRESC_LO +: 2]), .fire(socBFire));

    // set wins over clear, force set
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            evtFlags_reg <= 3'h0;
        end else if (busWrite && wordIdx == IDX_EVT_FLAGS && wb_sel_i[0]) begin
            evtFlags_reg <= ((evtFlags_reg & ~wb_dat_i[2:0]) | wb_dat_i[6:4]) |
                            {socBFire, socAFire, intFire};
        end else begin
            evtFlags_reg <= evtFlags_reg | {socBFire, socAFire, intFire};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            generalInterruptRequest <= 1'b0;
            conversionStartA <= 1'b0;
            conversionStartB <= 1'b0;
        end else begin
            generalInterruptRequest <= evtFlags_reg[0];
            conversionStartA <= socAFire;
            conversionStartB <= socBFire;
        end
    end

    a_period_event: assert property (@(posedge core_clk) disable iff (rst)
        (tick_reg && atPeriod) |=> counterAtPeriodEvent)
        else $error("period event missing");
    a_zero_event: assert property (@(posedge core_clk) disable iff (rst)
        (tick_reg && atZero) |=> counterAtZeroEvent)
        else $error("zero event missing");
    a_bypass_pass: assert property (@(posedge core_clk) disable iff (rst)
        tripCtl_reg[TRC_BYPASS] && $stable(tripCtl_reg) |=> pwmOutputA == $past(pwmInA))
        else $error("bypass altered output");
    a_phase_load: assert property (@(posedge core_clk) disable iff (rst)
        (tick_reg && syncPending_reg && control_reg[CTL_PHASE_EN] && !busWrite)
        |=> counter_reg == $past(phase_reg))
        else $error("phase not loaded");
    a_trip_irq: assert property (@(posedge core_clk) disable iff (rst)
        !tripCtl_reg[TRC_INT_EN] |=> !tripInterruptRequest)
        else $error("trip interrupt while disabled");
    a_oneshot_hold: assert property (@(posedge core_clk) disable iff (rst)
        (oneShot_reg != 4'h0 && !busWrite) |=> oneShot_reg != 4'h0)
        else $error("one-shot trip released");
    a_up_count: assert property (@(posedge core_clk) disable iff (rst)
        (tick_reg && mode == CNT_UP && !atPeriod && !syncAccepted && !syncPending_reg
         && !busWrite) |=> counter_reg == $past(counter_reg) + 16'h0001)
        else $error("up count wrong");
    a_synco_none: assert property (@(posedge core_clk) disable iff (rst)
        control_reg[CTL_SYNCO_LO +: 2] == 2'h3 ##1 control_reg[CTL_SYNCO_LO +: 2] == 2'h3
        |-> !syncChainOut)
        else $error("sync out with none selected");
endmodule // ptb_time_base
`default_nettype wire

//--- ptb_pkg.sv
package ptb_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_PHASE_EXT = 6'h02;
    localparam logic [5:0] IDX_PHASE = 6'h03;
    localparam logic [5:0] IDX_COUNTER = 6'h04;
    localparam logic [5:0] IDX_PERIOD = 6'h05;
    localparam logic [5:0] IDX_PERIOD_EXT = 6'h06;
    localparam logic [5:0] IDX_TRIP_SEL = 6'h10;
    localparam logic [5:0] IDX_TRIP_CTL = 6'h11;
    localparam logic [5:0] IDX_TRIP_FLAGS = 6'h12;
    localparam logic [5:0] IDX_EVT_SEL = 6'h13;
    localparam logic [5:0] IDX_EVT_FLAGS = 6'h14;
    localparam logic [5:0] IDX_DC_CTL = 6'h15;
    localparam logic [5:0] IDX_DC_CAPTURE = 6'h16;
    localparam logic [5:0] IDX_PERIOD_EXT_MIRROR = 6'h2A;
    localparam logic [5:0] IDX_PERIOD_MIRROR = 6'h2B;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    // Control fields
    localparam int CTL_MODE_LO = 0;
    localparam int CTL_PHASE_EN = 2;
    localparam int CTL_SYNC_IN_EN = 3;
    localparam int CTL_SYNCO_LO = 4;
    localparam int CTL_SW_SYNC = 6;
    localparam int CTL_PHASE_DIR = 7;
    localparam int CTL_DIV_LO = 8;
    localparam int CTL_DIV_HI = 11;
    // Trip control fields
    localparam int TRC_A_LO = 0;
    localparam int TRC_B_LO = 2;
    localparam int TRC_INT_EN = 4;
    localparam int TRC_BYPASS = 5;
    // Event select fields
    localparam int ES_INT_LO = 0;
    localparam int ES_SOCA_LO = 4;
    localparam int ES_SOCB_LO = 8;
    localparam int ES_PRESC_LO = 12;
    // Digital compare fields
    localparam int DC_CMP_EN_LO = 0;
    localparam int DC_TRIP_EN_LO = 4;
    localparam int DC_FILT_CAP = 8;
    localparam int DC_FILT_BLANK = 9;
    localparam int DC_BLANK_LEN_LO = 10;
    typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_UPDOWN, CNT_FROZEN} ptb_mode_t;
    typedef enum logic [1:0] {TRIP_HIGH, TRIP_LOW, TRIP_HIZ, TRIP_IGNORE} ptb_trip_act_t;
    typedef enum logic [1:0] {SO_SYNC_IN, SO_ZERO, SO_COMPARE_B_VALUE, SO_NONE} ptb_synco_t;
endpackage

//--- ptb_event_prescale.sv
`timescale 1ns/1ns
`default_nettype none
module ptb_event_prescale import ptb_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic eventIn,
    input wire logic [1:0] rate,
    output logic fire
);
    logic [1:0] count_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_reg <= 2'h0;
            fire <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (rate == 2'h0) begin
                count_reg <= 2'h0;
            end else if (eventIn) begin
                if (count_reg >= rate - 2'h1) begin
                    count_reg <= 2'h0;
                    fire <= 1'b1;
                end else begin
                    count_reg <= count_reg + 2'h1;
                end
            end
        end
    end
endmodule // ptb_event_prescale
`default_nettype wire

//--- ptb_neighbour_model.sv
`timescale 1ns/1ns
`default_nettype none
module ptb_neighbour_model (
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [2:0] faults,
    output logic syncChainIn,
    output logic [2:0] tripInputs
);
    always_ff @(posedge core_clk) begin
        syncChainIn <= fire;
        tripInputs <= faults;
    end
endmodule // ptb_neighbour_model
`default_nettype wire

//--- ptb_time_base_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ptb_time_base_tb import ptb_pkg::*;;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic fire = 1'b0;
    logic pwmInA = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h3;
    logic [31:0] dat = 32'h00000000;
    logic [2:0] faults = 3'h0;
    logic [31:0] rd;
    logic [2:0] tripIn;
    logic ack, syncIn, syncOut, aOut, aEn, zeroEv, prdEv, genIrq, tripIrq, socA;
    int badCount = 0;
    int checked = 0;
    int hit = 0;
    always #25 core_clk = ~core_clk;
    ptb_neighbour_model u_nb (.core_clk(core_clk), .fire(fire), .faults(faults),
        .syncChainIn(syncIn), .tripInputs(tripIn));
    ptb_time_base u_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
        .wb_ack_o(ack), .compareBValue(16'h0002), .pwmInA(pwmInA), .pwmInB(1'b0),
        .tripInputs(tripIn), .compOutputs(2'h0), .syncChainIn(syncIn),
        .syncChainOut(syncOut), .pwmOutputA(aOut), .pwmOutputAEn(aEn), .pwmOutputB(),
        .pwmOutputBEn(), .counterAtZeroEvent(zeroEv), .counterAtPeriodEvent(prdEv),
        .generalInterruptRequest(genIrq), .tripInterruptRequest(tripIrq),
        .conversionStartA(socA), .conversionStartB());
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            badCount++;
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] i, input logic [15:0] d);
        @(posedge core_clk);
        req <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= {16'h0000, d};
        @(posedge core_clk);
        while (ack !== 1'b1) @(posedge core_clk);
        req <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] i, input logic [31:0] exp);
        bus(1'b0, i, 16'h0000);
        chk(rd, exp);
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? zeroEv : (s == 1 ? prdEv : socA);
    endfunction
    task automatic gap(input int s, input int exp);
        int n;
        n = 0;
        repeat (2) do @(posedge core_clk); while (pick(s) !== 1'b1);
        do begin
            @(posedge core_clk);
            n++;
        end while (pick(s) !== 1'b1);
        chk(n, exp);
    endtask
    task automatic printVerdict();
        $display("checked %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        badCount++;
        printVerdict();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rdc(IDX_CONTROL, 32'h00000003);
        rdc(IDX_PERIOD_MIRROR, 32'h0000FFFF);
        bus(1'b1, IDX_PHASE_EXT, 16'h1234);
        rdc(IDX_PHASE_EXT, 32'h00000000);
        rdc(6'h3F, 32'h00000000);
        $display("test registers done");
        bus(1'b1, IDX_PERIOD, 16'h0004);
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, IDX_CONTROL, 16'h0100 | 16'(m));
            gap(0, m == 2 ? 16 : 10);
            gap(1, m == 2 ? 16 : 10);
        end
        bus(1'b1, IDX_CONTROL, 16'h0100);
        for (int r = 1; r < 4; r++) begin
            bus(1'b1, IDX_EVT_SEL, 16'h0090 | (16'(r) << 12));
            gap(2, r * 10);
        end
        bus(1'b1, IDX_CONTROL, 16'h0000);
        gap(0, 5);
        $display("test counter done");
        bus(1'b1, IDX_EVT_SEL, 16'h0000);
        bus(1'b1, IDX_EVT_FLAGS, 16'h0016);
        rdc(IDX_EVT_FLAGS, 32'h00000001);
        chk(genIrq, 1'b1);
        bus(1'b1, IDX_EVT_FLAGS, 16'h0001);
        repeat (2) @(posedge core_clk);
        chk(genIrq, 1'b0);
        $display("test flags done");
        faults <= 3'h1;
        bus(1'b1, IDX_TRIP_CTL, 16'h001D);
        repeat (3) @(posedge core_clk);
        chk({aOut, aEn}, 2'b11);
        bus(1'b1, IDX_TRIP_SEL, 16'h0001);
        pwmInA <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            bus(1'b1, IDX_TRIP_CTL, 16'h001C | 16'(a));
            repeat (3) @(posedge core_clk);
            chk({aOut & aEn, aEn}, a == 0 ? 2'b11 : (a == 2 ? 2'b00 : 2'b01));
        end
        pwmInA <= 1'b1;
        chk(tripIrq, 1'b1);
        bus(1'b1, IDX_TRIP_CTL, 16'h0021);
        repeat (3) @(posedge core_clk);
        chk({aOut, aEn}, 2'b11);
        $display("test trip done");
        bus(1'b1, IDX_PHASE, 16'h0123);
        bus(1'b1, IDX_CONTROL, 16'h000F);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (4) @(posedge core_clk) if (syncOut === 1'b1) hit++;
        chk(hit, 1);
        rdc(IDX_COUNTER, 32'h00000123);
        bus(1'b1, IDX_DC_CTL, 16'h0110);
        rdc(IDX_DC_CAPTURE, 32'h00010123);
        hit = 0;
        bus(1'b1, IDX_CONTROL, 16'h003F);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (4) @(posedge core_clk) if (syncOut === 1'b1) hit++;
        chk(hit, 0);
        $display("test sync done");
        printVerdict();
    end
endmodule // ptb_time_base_tb
`default_nettype wire
